// File: bench/tb.sv
`timescale 1ns/100ps
module tb import wfcr_pkg::*;;
    logic          i_clk;
    logic          i_rst_n;
    logic          i_ce;
    logic          i_bus_rxd;
    logic [7:0]    cal_h;
    logic [7:0]    cal_l;
    logic [7:0]    tgt;
    logic [7:0]    v;
    wfcr_spi_in_s  spi_in;
    wfcr_spi_out_s spi_out;
    logic          en;
    logic [7:0]    bt;
    logic          vld;
    int            mismatches = 0;
    int            cmp_count = 0;
    logic [31:0]   seed = 32'h556e8549;
    // sel, filter, target, lower, upper, ticks between edges
    int            cs [11][6] = '{'{0, 1, 160, 152, 168, 200}, '{0, 1, 160, 152, 168, 120},
        '{1, 1, 80, 76, 84, 100}, '{2, 1, 160, 152, 168, 155}, '{3, 1, 80, 76, 84, 60},
        '{0, 0, 180, 0, 255, 252}, '{1, 1, 180, 0, 255, 252}, '{0, 2, 180, 0, 255, 252},
        '{0, 3, 250, 0, 255, 624}, '{0, 3, 250, 0, 255, 1370}, '{0, 3, 250, 0, 255, 2620}};

    wfcr_top wfcr_top_i (.i_clk, .i_rst_n, .i_ce, .i_spi(spi_in), .o_spi(spi_out), .i_bus_rxd,
        .i_osc_calib_high_field(cal_h), .i_osc_calib_low_field(cal_l), .i_bit_time_target(tgt),
        .o_clock_recovery_enable(en), .o_bit_time(bt), .o_bit_time_valid(vld));
    wfcr_host wfcr_host_i (.i_clk, .o_spi(spi_in), .i_spi(spi_out));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] exp_bt(int b, int c, int f, int lo, int hi);
        int n;
        int d;
        n = (c + b / 2) / b;
        d = (c - n * b) / n;
        d = d >>> ((f == 1) ? 0 : (f == 0 || (f == 3 && n > 8)) ? 3 : (f == 2 || n < 4) ? 5 : 4);
        b = b + d;
        return 8'((b > hi) ? hi : (b < lo) ? lo : b);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic tol = 1'b0);
        cmp_count++;
        if (!(got === exp || (tol && (got === exp + 16'h1 || got === exp - 16'h1)))) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        wfcr_host_i.xfer(a, 1'b1, d, q);
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        wfcr_host_i.xfer(a, 1'b0, 8'h00, q);
        chk({8'h00, q}, {8'h00, e});
    endtask

    task automatic rstchk();
        rdc(WFCR_ADDR_CAL_HIGH, cal_h);
        rdc(WFCR_ADDR_CAL_LOW, cal_l);
        rdc(WFCR_ADDR_CTRL_ONE, 8'h04);
        rdc(WFCR_ADDR_CTRL_TWO, 8'h00);
        rdc(WFCR_ADDR_LIM_HIGH, 8'ha8);
        rdc(WFCR_ADDR_LIM_LOW, 8'h98);
        rdc(7'h40, 8'h00);
    endtask

    task automatic rec(input int s, input int f, input int t, input int lo, input int hi,
                       input int c);
        int w;
        wr(WFCR_ADDR_CTRL_ONE, 8'(f << WFCR_POS_FILT_SEL));
        wr(WFCR_ADDR_CTRL_TWO, 8'(s));
        wr(WFCR_ADDR_LIM_HIGH, 8'(hi));
        wr(WFCR_ADDR_LIM_LOW, 8'(lo));
        tgt = 8'(t);
        wr(WFCR_ADDR_CTRL_ONE, 8'((f << WFCR_POS_FILT_SEL) | 1));
        chk({15'h0000, en}, 16'h0001);
        repeat (10) @(negedge i_clk);
        i_bus_rxd = 1'b0;
        repeat (20) @(negedge i_clk);
        i_bus_rxd = 1'b1;
        // Nearest whole cycle, so the counted ticks land within one of c
        repeat ((((c * 25) << s) + 8) / 16 - 19) @(negedge i_clk);
        i_bus_rxd = 1'b0;
        w = 0;
        while (vld !== 1'b1 && w < 20) begin
            @(negedge i_clk);
            w++;
        end
        chk({7'h00, vld, bt}, {8'h01, exp_bt(t, c, f, lo, hi)}, 1'b1);
        repeat (20) @(negedge i_clk);
        i_bus_rxd = 1'b1;
    endtask

    task automatic test_done();
        $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #800_000;
        mismatches++;
        test_done();
    end

    initial begin
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_bus_rxd = 1'b1;
        tgt = 8'ha0;
        cal_h = 8'(rnd());
        cal_l = 8'(rnd());
        repeat (12) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (8) @(negedge i_clk);
        rstchk();
        wr(WFCR_ADDR_CAL_HIGH, ~cal_h);
        wr(WFCR_ADDR_CAL_LOW, ~cal_l);
        cal_l = 8'(rnd());
        rdc(WFCR_ADDR_CAL_HIGH, cal_h);
        rdc(WFCR_ADDR_CAL_LOW, cal_l);
        wr(WFCR_ADDR_CTRL_ONE, 8'hff);
        rdc(WFCR_ADDR_CTRL_ONE, 8'h0d);
        wr(WFCR_ADDR_CTRL_TWO, 8'hff);
        rdc(WFCR_ADDR_CTRL_TWO, 8'h03);
        for (int k = 0; k < 3; k++) begin
            v = 8'(rnd());
            wr(WFCR_ADDR_LIM_HIGH, v);
            wr(WFCR_ADDR_LIM_LOW, ~v);
            rdc(WFCR_ADDR_LIM_HIGH, v);
            rdc(WFCR_ADDR_LIM_LOW, ~v);
        end
        wr(WFCR_ADDR_CTRL_ONE, 8'h00);
        i_ce = 1'b0;
        tgt = 8'h5a;
        repeat (10) @(negedge i_clk);
        chk({8'h00, bt}, 16'h00a0);
        i_ce = 1'b1;
        i_rst_n = 1'b0;
        repeat (12) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (8) @(negedge i_clk);
        rstchk();
        for (int k = 0; k < 11; k++)
            rec(cs[k][0], cs[k][1], cs[k][2], cs[k][3], cs[k][4],
                cs[k][5]);
        // Spacings 1..10 bits, kept a sixth of a bit away from rounding edges
        for (int k = 0; k < 4; k++)
            rec(int'(rnd() % 2), int'(rnd() % 4), 180, 170, 190,
                120 + 180 * int'(rnd() % 10) + int'(rnd() % 120));
        test_done();
    end
endmodule // tb

// File: bench/wfcr_host.sv
`timescale 1ns/100ps
module wfcr_host import wfcr_pkg::*; (
    // Clock
    input  wire logic          i_clk,
    // Serial pins
    output wfcr_spi_in_s       o_spi,
    input  wire wfcr_spi_out_s i_spi
);
    // Half bit covers the 4..5 cycle pin-to-output latency
    localparam int HALF = 8;
    initial o_spi = '{sck: 1'b0, csn: 1'b1, mosi: 1'b0};
    task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {d, wr, a};
        q = 8'h00;
        o_spi.csn = 1'b0;
        for (int i = 0; i < 16; i++) begin
            o_spi.mosi = f[i];
            repeat (HALF) @(negedge i_clk);
            if (i > 7)
                q[i-8] = (i_spi.miso_oe === 1'b1) ? i_spi.miso : 1'bx;
            o_spi.sck = 1'b1;
            repeat (HALF) @(negedge i_clk);
            o_spi.sck = 1'b0;
        end
        repeat (HALF) @(negedge i_clk);
        o_spi.csn = 1'b1;
        // Idle data line must not keep a valid-looking bit
        o_spi.mosi = ~o_spi.mosi;
        repeat (HALF) @(negedge i_clk);
    endtask
endmodule // wfcr_host

// File: bench/wfcr_sva.sv
`timescale 1ns/100ps
module wfcr_sva import wfcr_pkg::*; (
    // Clock and reset
    input wire logic          i_clk,
    input wire logic          i_rst_n,
    input wire logic          i_ce,
    // Watched ports
    input wire wfcr_spi_in_s  i_spi,
    input wire wfcr_spi_out_s o_spi,
    input wire logic          i_bus_rxd,
    input wire logic [7:0]    i_bit_time_target,
    input wire logic          o_clock_recovery_enable,
    input wire logic [7:0]    o_bit_time,
    input wire logic          o_bit_time_valid
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_idle;
        i_spi.csn [*8];
    endsequence
    sequence s_held_off;
        !$past(o_clock_recovery_enable) && $past(i_rst_n) && $past(i_ce);
    endsequence
    property p_rst; $rose(i_rst_n) |-> !o_clock_recovery_enable && !o_bit_time_valid; endproperty
    property p_oe_on; $fell(i_spi.csn) |-> ##[2:6] o_spi.miso_oe; endproperty
    property p_oe_off; s_idle |-> !o_spi.miso_oe; endproperty
    property p_freeze;
        !i_ce |=> $stable(o_bit_time) && $stable(o_clock_recovery_enable);
    endproperty
    property p_pulse; o_bit_time_valid |=> !o_bit_time_valid; endproperty
    property p_val_en; o_bit_time_valid |-> $past(o_clock_recovery_enable); endproperty
    property p_val_rxd; o_bit_time_valid |-> !$past(i_bus_rxd, 3); endproperty
    property p_tgt; s_held_off |-> o_bit_time == $past(i_bit_time_target); endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
    a_oe_off: assert property (p_oe_off) else $error("miso driven while idle");
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");
    a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
    a_val_en: assert property (p_val_en) else $error("valid while disabled");
    a_val_rxd: assert property (p_val_rxd) else $error("valid without falling edge");
    a_tgt: assert property (p_tgt) else $error("bit time not at target");
endmodule // wfcr_sva

bind wfcr_top wfcr_sva wfcr_sva_i (.i_clk, .i_rst_n, .i_ce, .i_spi, .o_spi, .i_bus_rxd,
    .i_bit_time_target, .o_clock_recovery_enable, .o_bit_time, .o_bit_time_valid);

// File: hdl/wfcr_pin_sync.sv
`timescale 1ns/100ps
module wfcr_pin_sync import wfcr_pkg::*; #(
    parameter logic RST_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    // Pin and settled level
    input  wire logic i_pin,
    output logic      o_level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } wfcr_sync_s;

    wfcr_sync_s st;
    wfcr_sync_s next_st;

    // First stage feeds only the second; level moves once stages 2 and 3 agree
    always_comb begin
        next_st    = st;
        next_st.s1 = i_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st <= {4{RST_LEVEL}};
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_level = st.level;

endmodule // wfcr_pin_sync

// File: hdl/wfcr_pkg.sv
package wfcr_pkg;

    // Register addresses (7-bit)
    localparam logic [6:0] WFCR_ADDR_CAL_HIGH = 7'h3a;
    localparam logic [6:0] WFCR_ADDR_CAL_LOW  = 7'h3b;
    localparam logic [6:0] WFCR_ADDR_CTRL_ONE = 7'h3c;
    localparam logic [6:0] WFCR_ADDR_CTRL_TWO = 7'h3d;
    localparam logic [6:0] WFCR_ADDR_LIM_HIGH = 7'h3e;
    localparam logic [6:0] WFCR_ADDR_LIM_LOW  = 7'h3f;

    // Field positions
    localparam int WFCR_POS_ENABLE   = 0;
    localparam int WFCR_POS_FILT_SEL = 2;
    localparam int WFCR_POS_CLK_SEL  = 0;

    // Reset values
    localparam logic [7:0] WFCR_RST_CAL      = 8'h00;
    localparam logic [7:0] WFCR_RST_CTRL_ONE = 8'h04;
    localparam logic [7:0] WFCR_RST_CTRL_TWO = 8'h00;
    localparam logic [7:0] WFCR_RST_LIM_HIGH = 8'ha8;
    localparam logic [7:0] WFCR_RST_LIM_LOW  = 8'h98;

    // Serial frame
    localparam logic [4:0] WFCR_FRAME_BITS = 5'h10;
    localparam logic [4:0] WFCR_ADDR_BITS  = 5'h08;

    // Recovery clock: fractional tick generator, 16-bit phase
    localparam longint WFCR_CLK_HZ      = 125_000_000;
    localparam longint WFCR_RCLK_TOP_HZ = 80_000_000;
    localparam logic [15:0] WFCR_PHASE_STEP =
        16'((WFCR_RCLK_TOP_HZ * 65536) / WFCR_CLK_HZ);

    // Filter selector codes and shift equivalents of the time constants
    localparam logic [1:0] WFCR_FILT_TC8   = 2'h0;
    localparam logic [1:0] WFCR_FILT_TC0   = 2'h1;
    localparam logic [1:0] WFCR_FILT_TC32  = 2'h2;
    localparam logic [1:0] WFCR_FILT_ADAPT = 2'h3;
    localparam logic [2:0] WFCR_SHIFT_TC8  = 3'h3;
    localparam logic [2:0] WFCR_SHIFT_TC16 = 3'h4;
    localparam logic [2:0] WFCR_SHIFT_TC32 = 3'h5;
    localparam logic [3:0] WFCR_MAX_SPACING = 4'ha;

    typedef struct packed {
        logic sck;
        logic csn;
        logic mosi;
    } wfcr_spi_in_s;

    typedef struct packed {
        logic miso;
        logic miso_oe;
    } wfcr_spi_out_s;

endpackage

// File: hdl/wfcr_top.sv
`timescale 1ns/100ps
// What this block does
// [R1] The high calibration byte is read-only and writes to it change nothing.
// [R2] The low calibration byte is read-only and clears to zero on reset.
// [R3] Filter selector codes 00, 01, 10, 11 give time constants 8, 0, 32 and adaptive.
// [R4] Adaptive mode uses 32, 16 or 8 for falling-edge spacings of 1-3, 4-8 or 9-10 bits.
// [R5] Bit 0 of control byte one switches clock and data recovery on or off.
// [R6] Control byte one resets to 0000 0100: recovery off, filter code 01.
// [R7] Bits 7:4 of control byte one and 7:2 of control byte two read as zero.
// [R8] The clock selector gives 80, 40, 20 or 10 MHz recovery clock and resets to 00.
// [R9] The host programs matching target and limit values for its clock and baud rate.
// [R10] The host avoids clock and baud combinations that overflow the bit-time count.
// [R11] The host avoids clock and baud combinations with too little precision.
// [R12] A recovered bit time above the upper limit is clamped to it.
// [R13] A recovered bit time below the lower limit is clamped to it.
// [R14] The upper limit byte resets to 1010 1000.
// [R15] The lower limit byte resets to 1001 1000.
// [R16] Access is a 16-bit serial frame: 7-bit address, access-mode bit, then data byte.
// [R17] When enabled, bit time is counted in recovery clock ticks, filtered and clamped.
module wfcr_top import wfcr_pkg::*; (
    // Clock, reset, enable
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_ce,
    // Serial register port
    input  wire wfcr_spi_in_s  i_spi,
    output wfcr_spi_out_s      o_spi,
    // Bus receive line and oscillator calibration
    input  wire logic          i_bus_rxd,
    input  wire logic [7:0]    i_osc_calib_high_field,
    input  wire logic [7:0]    i_osc_calib_low_field,
    input  wire logic [7:0]    i_bit_time_target,
    // To the frame detector
    output logic               o_clock_recovery_enable,
    output logic [7:0]         o_bit_time,
    output logic               o_bit_time_valid
);

    typedef struct packed {
        logic          sck_q;
        logic          csn_q;
        logic          rxd_q;
        logic [4:0]    bit_cnt;
        logic [15:0]   shift_in;
        logic [7:0]    shift_out;
        wfcr_spi_out_s spi;
        logic [7:0]    cal_high;
        logic [7:0]    cal_low;
        logic          clock_recovery_enable;
        logic [1:0]    filter_time_const_sel;
        logic [1:0]    recovery_clock_sel;
        logic [7:0]    bit_time_upper_limit;
        logic [7:0]    bit_time_lower_limit;
        logic [15:0]   phase;
        logic [11:0]   tick_cnt;
        logic          armed;
        logic [7:0]    bit_time;
        logic          bit_time_valid;
    } wfcr_state_s;

    wfcr_state_s st;
    wfcr_state_s next_st;
    logic        sck_lvl;
    logic        csn_lvl;
    logic        mosi_lvl;
    logic        rxd_lvl;

    wfcr_pin_sync #(.RST_LEVEL(1'b0)) u_sync_sck (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_spi.sck),
        .o_level (sck_lvl)
    );
    wfcr_pin_sync #(.RST_LEVEL(1'b1)) u_sync_csn (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_spi.csn),
        .o_level (csn_lvl)
    );
    wfcr_pin_sync #(.RST_LEVEL(1'b0)) u_sync_mosi (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_spi.mosi),
        .o_level (mosi_lvl)
    );
    wfcr_pin_sync #(.RST_LEVEL(1'b1)) u_sync_rxd (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_pin   (i_bus_rxd),
        .o_level (rxd_lvl)
    );

    function automatic logic [7:0] read_reg(input wfcr_state_s s, input logic [6:0] addr);
        logic [7:0] d;
        d = 8'h00;
        unique case (addr)
            WFCR_ADDR_CAL_HIGH: d = s.cal_high;
            WFCR_ADDR_CAL_LOW:  d = s.cal_low;
            WFCR_ADDR_CTRL_ONE: begin
                d[WFCR_POS_ENABLE]                   = s.clock_recovery_enable;
                d[WFCR_POS_FILT_SEL +: 2]            = s.filter_time_const_sel;
            end
            WFCR_ADDR_CTRL_TWO: d[WFCR_POS_CLK_SEL +: 2] = s.recovery_clock_sel; // [R7]
            WFCR_ADDR_LIM_HIGH: d = s.bit_time_upper_limit;
            WFCR_ADDR_LIM_LOW:  d = s.bit_time_lower_limit;
            default:            d = 8'h00;
        endcase
        return d;
    endfunction

    always_comb begin
        logic [15:0] sin;
        logic [16:0] acc;
        logic [3:0]  spacing;
        logic [12:0] half;
        logic [12:0] multiple;
        logic signed [14:0] err;
        logic signed [14:0] err_bit;
        logic signed [14:0] upd;
        logic [2:0]  shift;
        logic [7:0]  wdata;
        sin      = st.shift_in;
        acc      = 17'h00000;
        spacing  = 4'h0;
        half     = 13'h0000;
        multiple = 13'h0000;
        err      = 15'sh0000;
        err_bit  = 15'sh0000;
        upd      = 15'sh0000;
        shift    = WFCR_SHIFT_TC8;
        wdata    = st.shift_in[15:8];
        next_st  = st;

        next_st.sck_q          = sck_lvl;
        next_st.csn_q          = csn_lvl;
        next_st.rxd_q          = rxd_lvl;
        next_st.bit_time_valid = 1'b0;
        next_st.cal_high       = i_osc_calib_high_field; // [R1]
        next_st.cal_low        = i_osc_calib_low_field;

        // Serial frame, LSB first, sampled on rising clock, shifted on falling
        if (st.csn_q && !csn_lvl) begin
            next_st.bit_cnt     = 5'h00;
            next_st.spi.miso_oe = 1'b1;
            next_st.spi.miso    = 1'b0;
        end else if (!csn_lvl && !st.sck_q && sck_lvl) begin
            sin              = {mosi_lvl, st.shift_in[15:1]};
            next_st.shift_in = sin;
            if (st.bit_cnt <= WFCR_FRAME_BITS) begin
                next_st.bit_cnt = st.bit_cnt + 5'h01;
            end
            if (st.bit_cnt + 5'h01 == WFCR_ADDR_BITS) begin
                next_st.shift_out = read_reg(st, sin[14:8]); // [R16]
            end
        end else if (!csn_lvl && st.sck_q && !sck_lvl && st.bit_cnt >= WFCR_ADDR_BITS) begin
            next_st.spi.miso  = st.shift_out[0];
            next_st.shift_out = {1'b0, st.shift_out[7:1]};
        end else if (!st.csn_q && csn_lvl) begin
            next_st.spi.miso_oe = 1'b0;
            next_st.spi.miso    = 1'b0;
            // Only a whole frame with the write bit commits; short or long ones drop
            if (st.bit_cnt == WFCR_FRAME_BITS && st.shift_in[7]) begin // [R16]
                unique case (st.shift_in[6:0])
                    WFCR_ADDR_CTRL_ONE: begin
                        next_st.clock_recovery_enable = wdata[WFCR_POS_ENABLE]; // [R5]
                        next_st.filter_time_const_sel = wdata[WFCR_POS_FILT_SEL +: 2];
                    end
                    WFCR_ADDR_CTRL_TWO: next_st.recovery_clock_sel = wdata[WFCR_POS_CLK_SEL +: 2];
                    WFCR_ADDR_LIM_HIGH: next_st.bit_time_upper_limit = wdata;
                    WFCR_ADDR_LIM_LOW:  next_st.bit_time_lower_limit = wdata;
                    default: ;  // Calibration and unmapped addresses ignore writes [R1]
                endcase
            end
        end

        // Recovery: tick rate is 80 MHz halved per selector step
        if (!st.clock_recovery_enable) begin // [R5]
            next_st.phase    = 16'h0000;
            next_st.tick_cnt = 12'h000;
            next_st.armed    = 1'b0;
            next_st.bit_time = i_bit_time_target;
        end else begin
            acc           = {1'b0, st.phase}
                          + {1'b0, WFCR_PHASE_STEP >> st.recovery_clock_sel}; // [R8]
            next_st.phase = acc[15:0];
            if (acc[16] && st.tick_cnt != 12'hfff) begin
                next_st.tick_cnt = st.tick_cnt + 12'h001; // [R17]
            end
            if (st.rxd_q && !rxd_lvl) begin
                next_st.tick_cnt = 12'h000;
                next_st.armed    = 1'b1;
                half             = {6'h00, st.bit_time[7:1]};
                for (int i = 1; i <= 11; i++) begin
                    multiple = 13'(i) * {5'h00, st.bit_time};
                    if ({1'b0, st.tick_cnt} + half >= multiple) begin
                        spacing = 4'(i);
                    end
                end
                unique case (st.filter_time_const_sel) // [R3]
                    WFCR_FILT_TC8:  shift = WFCR_SHIFT_TC8;
                    WFCR_FILT_TC0:  shift = 3'h0;
                    WFCR_FILT_TC32: shift = WFCR_SHIFT_TC32;
                    WFCR_FILT_ADAPT: begin
                        if (spacing <= 4'h3) begin
                            shift = WFCR_SHIFT_TC32; // [R4]
                        end else if (spacing <= 4'h8) begin
                            shift = WFCR_SHIFT_TC16; // [R4]
                        end else begin
                            shift = WFCR_SHIFT_TC8;  // [R4]
                        end
                    end
                endcase
                // Idle gaps longer than ten bits carry no bit-time information
                if (st.armed && spacing != 4'h0 && spacing <= WFCR_MAX_SPACING) begin
                    multiple = 13'(spacing) * {5'h00, st.bit_time};
                    err      = $signed({3'b000, st.tick_cnt}) - $signed({2'b00, multiple});
                    err_bit  = err / $signed({11'h000, spacing});
                    upd      = $signed({7'h00, st.bit_time}) + (err_bit >>> shift);
                    if (upd > $signed({7'h00, st.bit_time_upper_limit})) begin
                        next_st.bit_time = st.bit_time_upper_limit; // [R12]
                    end else if (upd < $signed({7'h00, st.bit_time_lower_limit})) begin
                        next_st.bit_time = st.bit_time_lower_limit; // [R13]
                    end else begin
                        next_st.bit_time = upd[7:0];
                    end
                    next_st.bit_time_valid = 1'b1; // [R17]
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st                       <= '0;
            st.csn_q                 <= 1'b1;
            st.rxd_q                 <= 1'b1;
            st.cal_high              <= WFCR_RST_CAL;
            st.cal_low               <= WFCR_RST_CAL; // [R2]
            st.clock_recovery_enable <= WFCR_RST_CTRL_ONE[WFCR_POS_ENABLE]; // [R6]
            st.filter_time_const_sel <= WFCR_RST_CTRL_ONE[WFCR_POS_FILT_SEL +: 2]; // [R6]
            st.recovery_clock_sel    <= WFCR_RST_CTRL_TWO[WFCR_POS_CLK_SEL +: 2]; // [R8]
            st.bit_time_upper_limit  <= WFCR_RST_LIM_HIGH; // [R14]
            st.bit_time_lower_limit  <= WFCR_RST_LIM_LOW;  // [R15]
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_spi                   = st.spi;
    assign o_clock_recovery_enable = st.clock_recovery_enable;
    assign o_bit_time              = st.bit_time;
    assign o_bit_time_valid        = st.bit_time_valid;

endmodule // wfcr_top
